// file: dtpf_top.sv
// dead-time insertion, pattern generation and fault protection unit
// Notes on behaviour
// - enabled channel hands its pin pair to the override enable bits
// - four equal dead-time generators share the dead-time registers
// - low and high side dead times separate, each double buffered
// - 8-bit dead-time counter steps down each clock, stops at zero
// - non-zero dead-time counter forces both sides low
// - rising edge loads low side time, falling edge high side
// - pattern mode bypasses dead time and reuses its registers
// - in pattern mode overridden pins carry channel a waveform
// - buffer to active transfers happen only at update
// - each event channel maskable, enabled ones ored into fault
// - clear-override action clears all override enable bits
// - direction-clear action clears port direction bits
// - fault sets fault flag and timer error flag
// - fault action lands within two clocks, hardware only
// - latched mode waits for no fault and flag cleared, then update
// - cycle mode waits only for no fault, then update
// - restoring update reloads override or direction bits
// - lock bit blocks writes to control, override and mask
// - debugger break acts as fault source by default
// - common waveform bit feeds channel a to all generators
// - channel enable bits gate each channel's pin pair outside pattern mode, generators always run
// - action codes 00 off, 01 clear override, 11 clear direction
// - restart bit clear is latched, set is cycle by cycle
// - debug ignore bit stops breaks raising a fault
// - fault flag cleared by writing one, zero leaves it
`timescale 1ns/1ps
`default_nettype none
module dtpf_top #(
    parameter int DT_W = 8
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [5:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic [3:0]  wave_i,
    input  wire logic        update_i,
    input  wire logic        lock_upd_i,
    input  wire logic        lock_i,
    input  wire logic [7:0]  fault_event_i,
    input  wire logic        debug_break_i,
    output logic      [7:0]  pin_o,
    output logic      [7:0]  pin_oe_o,
    output logic      [7:0]  dir_clr_o,
    output logic      [7:0]  dir_set_o,
    output logic             err_set_o,
    output logic             fault_o
);
    typedef struct packed {
        logic [5:0]             ctrl;
        logic [7:0]             mask;
        logic                   ign;
        logic                   mode;
        logic [1:0]             act;
        logic                   fdf;
        logic                   lsv;
        logic                   hsv;
        logic [DT_W-1:0]        low_side_dead_time;
        logic [DT_W-1:0]        high_side_dead_time;
        logic [DT_W-1:0]        dtlsb;
        logic [DT_W-1:0]        dthsb;
        logic [7:0]             pin_override_enable_bits;
        dtpf_pkg::dtpf_fstate_t fst;
        logic [7:0]             pin;
        logic [7:0]             pin_oe;
        logic [7:0]             dclr;
        logic [7:0]             dset;
        logic                   err;
        logic                   ack;
        logic [7:0]             dat;
    } dtpf_state_t;

    dtpf_state_t q;
    dtpf_state_t d;

    logic [3:0] ch_wave;
    logic [3:0] ls_w;
    logic [3:0] hs_w;
    logic       fault_w;
    logic       req;
    logic       wr;
    logic [3:0] idx;
    logic [7:0] wd;
    logic       pattern_mode_bit;

    // pin pair of each enabled channel: pins 2k and 2k+1
    function automatic logic [7:0] pair_mask(input logic [3:0] en);
        logic [7:0] m;
        m = 8'h00;
        for (int k = 0; k < dtpf_pkg::NCH; k++) begin
            m[2*k]   = en[k];
            m[2*k+1] = en[k];
        end
        return m;
    endfunction : pair_mask

    assign req = wb_cyc_i & wb_stb_i & ~q.ack;
    assign wr  = req & wb_we_i & wb_sel_i[0];
    assign idx = wb_adr_i[5:2];
    assign wd  = wb_dat_i[7:0];
    assign pattern_mode_bit = q.ctrl[dtpf_pkg::CTRL_PGM];

    // common mode ignores channels b to d
    assign ch_wave = q.ctrl[dtpf_pkg::CTRL_COMMON_WAVEFORM_BIT] ? {4{wave_i[0]}}
                                                : wave_i;

    for (genvar k = 0; k < dtpf_pkg::NCH; k++) begin : g_dtg
        dtpf_dtg #(
            .DT_W (DT_W)
        ) u_dtg (
            .clk_i   (clk_i),
            .rst_i   (rst_i),
            .wave_i  (ch_wave[k]),
            .dt_ls_i (q.low_side_dead_time),
            .dt_hs_i (q.high_side_dead_time),
            .ls_o    (ls_w[k]),
            .hs_o    (hs_w[k])
        );
    end

    dtpf_fault u_fault (
        .clk_i        (clk_i),
        .rst_i        (rst_i),
        .event_i      (fault_event_i),
        .mask_i       (q.mask),
        .dbg_break_i  (debug_break_i),
        .dbg_ignore_i (q.ign),
        .action_i     (q.act),
        .fault_o      (fault_w)
    );

    always_comb begin
        logic [7:0] rv;
        d      = q;
        rv     = pattern_mode_bit ? q.dtlsb : pair_mask(q.ctrl[3:0]);
        d.ack  = req;
        d.err  = 1'b0;
        d.dclr = 8'h00;
        d.dset = 8'h00;

        unique case (idx)
            dtpf_pkg::IDX_CTRL:    d.dat = {2'b00, q.ctrl};
            dtpf_pkg::IDX_MASK:    d.dat = q.mask;
            dtpf_pkg::IDX_FDCTRL:  d.dat = {3'b000, q.ign, 1'b0, q.mode,
                                           q.act};
            dtpf_pkg::IDX_STATUS:  d.dat = {5'h00, q.fdf, q.hsv, q.lsv};
            dtpf_pkg::IDX_BOTH,
            dtpf_pkg::IDX_LOW_SIDE_DEAD_TIME:    d.dat = q.low_side_dead_time;
            dtpf_pkg::IDX_BOTHBUF,
            dtpf_pkg::IDX_LOW_SIDE_DEAD_TIME_BUFFER: d.dat = q.dtlsb;
            dtpf_pkg::IDX_HIGH_SIDE_DEAD_TIME:    d.dat = q.high_side_dead_time;
            dtpf_pkg::IDX_DTHSBUF: d.dat = q.dthsb;
            dtpf_pkg::IDX_OOE:     d.dat = q.pin_override_enable_bits;
            default:               d.dat = 8'h00;
        endcase

        // lock update from the timer holds the buffers back
        if (update_i && !lock_upd_i) begin
            if (q.lsv) begin
                d.low_side_dead_time = q.dtlsb;
                d.lsv  = 1'b0;
                if (pattern_mode_bit && q.fst == dtpf_pkg::DTPF_RUN) begin
                    d.pin_override_enable_bits = q.dtlsb;
                end
            end
            if (q.hsv) begin
                d.high_side_dead_time = q.dthsb;
                d.hsv  = 1'b0;
            end
        end

        if (wr) begin
            unique case (idx)
                dtpf_pkg::IDX_CTRL: begin
                    if (!lock_i) d.ctrl = wd[5:0];
                end
                dtpf_pkg::IDX_MASK: begin
                    if (!lock_i) d.mask = wd;
                end
                dtpf_pkg::IDX_FDCTRL: begin
                    d.ign  = wd[dtpf_pkg::FD_IGN];
                    d.mode = wd[dtpf_pkg::FD_MODE];
                    d.act  = wd[1:0];
                end
                dtpf_pkg::IDX_STATUS: begin
                    if (wd[dtpf_pkg::ST_FDF]) d.fdf = 1'b0;
                end
                dtpf_pkg::IDX_BOTH: begin
                    d.low_side_dead_time = wd;
                    d.high_side_dead_time = wd;
                end
                dtpf_pkg::IDX_BOTHBUF: begin
                    d.dtlsb = wd;
                    d.dthsb = wd;
                    d.lsv   = 1'b1;
                    d.hsv   = 1'b1;
                end
                dtpf_pkg::IDX_LOW_SIDE_DEAD_TIME:    d.low_side_dead_time = wd;
                dtpf_pkg::IDX_HIGH_SIDE_DEAD_TIME:    d.high_side_dead_time = wd;
                dtpf_pkg::IDX_LOW_SIDE_DEAD_TIME_BUFFER: begin
                    d.dtlsb = wd;
                    d.lsv   = 1'b1;
                end
                dtpf_pkg::IDX_DTHSBUF: begin
                    d.dthsb = wd;
                    d.hsv   = 1'b1;
                end
                dtpf_pkg::IDX_OOE: begin
                    if (!lock_i && !q.fdf) d.pin_override_enable_bits = wd;
                end
                default: begin
                end
            endcase
        end

        // placed after the bus so a new fault beats a flag clear
        if (fault_w) begin
            d.fdf = 1'b1;
            d.err = 1'b1;
            d.fst = dtpf_pkg::DTPF_FAULT;
            if (q.act == dtpf_pkg::DTPF_ACT_CLR) begin
                d.pin_override_enable_bits = 8'h00;
            end
            if (q.act == dtpf_pkg::DTPF_ACT_DIR) begin
                d.dclr = rv;
            end
        end else if (q.fst == dtpf_pkg::DTPF_FAULT && update_i &&
                     (q.mode || !q.fdf)) begin
            d.fst = dtpf_pkg::DTPF_RUN;
            if (q.act == dtpf_pkg::DTPF_ACT_CLR) begin
                d.pin_override_enable_bits = rv;
            end
            if (q.act == dtpf_pkg::DTPF_ACT_DIR) begin
                d.dset = rv;
            end
        end

        // pin outputs take one clock; overrides follow the new ooe
        if (pattern_mode_bit) begin
            d.pin    = {8{wave_i[0]}};
            d.pin_oe = d.pin_override_enable_bits;
        end else begin
            for (int k = 0; k < dtpf_pkg::NCH; k++) begin
                d.pin[2*k]   = ls_w[k];
                d.pin[2*k+1] = hs_w[k];
            end
            d.pin_oe = d.pin_override_enable_bits & pair_mask(q.ctrl[3:0]);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q      <= '0;
            q.ctrl <= dtpf_pkg::CTRL_RST;
            q.pin_override_enable_bits  <= dtpf_pkg::REG_RST;
        end else begin
            q <= d;
        end
    end

    assign wb_dat_o  = {24'h000000, q.dat};
    assign wb_ack_o  = q.ack;
    assign pin_o     = q.pin;
    assign pin_oe_o  = q.pin_oe;
    assign dir_clr_o = q.dclr;
    assign dir_set_o = q.dset;
    assign err_set_o = q.err;
    assign fault_o   = q.fst;

    logic ev_hit;
    assign ev_hit = (q.act != dtpf_pkg::DTPF_ACT_NONE) &&
                    ((|(fault_event_i & q.mask)) ||
                     (debug_break_i && !q.ign));

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    clr_ooe_a: assert property (ev_hit && q.act == dtpf_pkg::DTPF_ACT_CLR
        && !update_i |-> ##[1:3] pin_oe_o == 8'h00)
        else $error("override enables not cleared by fault");
    dir_clr_a: assert property (ev_hit && q.act == dtpf_pkg::DTPF_ACT_DIR
        && pattern_mode_bit && q.dtlsb != 8'h00 |-> ##[1:2] dir_clr_o != 8'h00)
        else $error("direction clear missing after fault");
    flag_set_a: assert property (ev_hit |-> ##[1:2] q.fdf && err_set_o)
        else $error("fault flag not set within two clocks");
    w1c_flag_a: assert property (wr && idx == dtpf_pkg::IDX_STATUS &&
        wd[dtpf_pkg::ST_FDF] && !fault_w |=> !q.fdf)
        else $error("fault flag not cleared by one write");
    lock_ctrl_a: assert property (lock_i |=> $stable(q.ctrl) &&
        $stable(q.mask))
        else $error("locked register changed");
    buf_xfer_a: assert property (update_i && !lock_upd_i && q.lsv |=>
        q.low_side_dead_time == $past(q.dtlsb) || $past(wr))
        else $error("low side buffer not transferred at update");
    no_xfer_a: assert property (!update_i && !wr |=> $stable(q.low_side_dead_time) &&
        $stable(q.high_side_dead_time))
        else $error("dead time changed without update");
    cyc_restore_a: assert property (q.fst && q.mode && !fault_w &&
        update_i |=> !q.fst)
        else $error("cycle mode did not restore at update");
    latch_hold_a: assert property (q.fst && !q.mode && q.fdf |=> q.fst)
        else $error("latched mode left fault with flag set");
    ack_once_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held for two cycles");

    fault_c: cover property (ev_hit ##2 q.fst);
    restore_c: cover property (q.fst ##1 !q.fst && q.pin_override_enable_bits != 8'h00);
    pattern_c: cover property (pattern_mode_bit && pin_oe_o != 8'h00);
    dead_c: cover property ($rose(wave_i[0]) ##1 !pin_o[0] ##1 !pin_o[0]);
endmodule : dtpf_top
`default_nettype wire

// file: dtpf_pkg.sv
// constants and types shared by the dead-time, pattern and fault unit
package dtpf_pkg;
    localparam int NCH  = 4;
    localparam int NPIN = 8;
    localparam int RW   = 8;

    // register indices, byte address is four times the index
    localparam logic [3:0] IDX_CTRL    = 4'h0;
    localparam logic [3:0] IDX_MASK    = 4'h2;
    localparam logic [3:0] IDX_FDCTRL  = 4'h3;
    localparam logic [3:0] IDX_STATUS  = 4'h4;
    localparam logic [3:0] IDX_BOTH    = 4'h6;
    localparam logic [3:0] IDX_BOTHBUF = 4'h7;
    localparam logic [3:0] IDX_LOW_SIDE_DEAD_TIME    = 4'h8;
    localparam logic [3:0] IDX_HIGH_SIDE_DEAD_TIME    = 4'h9;
    localparam logic [3:0] IDX_LOW_SIDE_DEAD_TIME_BUFFER = 4'ha;
    localparam logic [3:0] IDX_DTHSBUF = 4'hb;
    localparam logic [3:0] IDX_OOE     = 4'hc;

    // field positions
    localparam int CTRL_PGM  = 5;
    localparam int CTRL_COMMON_WAVEFORM_BIT = 4;
    localparam int FD_IGN    = 4;
    localparam int FD_MODE   = 2;
    localparam int ST_FDF    = 2;
    localparam int ST_HSV    = 1;
    localparam int ST_LSV    = 0;

    localparam logic [5:0]    CTRL_RST = 6'h00;
    localparam logic [RW-1:0] REG_RST  = 8'h00;

    typedef enum logic [1:0] {
        DTPF_ACT_NONE = 2'b00,
        DTPF_ACT_CLR  = 2'b01,
        DTPF_ACT_RSV  = 2'b10,
        DTPF_ACT_DIR  = 2'b11
    } dtpf_act_t;

    typedef enum logic {
        DTPF_RUN   = 1'b0,
        DTPF_FAULT = 1'b1
    } dtpf_fstate_t;
endpackage : dtpf_pkg

// file: dtpf_dtg.sv
// one dead-time generator: complementary low and high side with dead time
`timescale 1ns/1ps
`default_nettype none
module dtpf_dtg #(
    parameter int DT_W = 8
) (
    input  wire logic            clk_i,
    input  wire logic            rst_i,
    input  wire logic            wave_i,
    input  wire logic [DT_W-1:0] dt_ls_i,
    input  wire logic [DT_W-1:0] dt_hs_i,
    output logic                 ls_o,
    output logic                 hs_o
);
    typedef struct packed {
        logic            prev;
        logic [DT_W-1:0] cnt;
    } dtpf_dtg_t;

    dtpf_dtg_t q;
    dtpf_dtg_t d;
    logic      edge_w;

    assign edge_w = wave_i ^ q.prev;

    always_comb begin
        d      = q;
        d.prev = wave_i;
        if (edge_w) begin
            d.cnt = wave_i ? dt_ls_i : dt_hs_i;
        end else if (q.cnt != '0) begin
            d.cnt = q.cnt - 1'b1;
        end
    end

    // edge counts as dead time too, so no glitch before the reload lands
    assign ls_o = wave_i & ~edge_w & (q.cnt == '0);
    assign hs_o = ~wave_i & ~edge_w & (q.cnt == '0);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    dead_off_a: assert property ((q.cnt != '0) |-> !ls_o && !hs_o)
        else $error("output on during dead time");
    rise_load_a: assert property ($rose(wave_i) |=> q.cnt == $past(dt_ls_i))
        else $error("rising edge did not load low side time");
    cnt_dec_a: assert property ((q.cnt != '0) && !edge_w |=>
        q.cnt == $past(q.cnt) - 1'b1)
        else $error("dead time counter did not step down");
endmodule : dtpf_dtg
`default_nettype wire

// file: dtpf_fault.sv
// fault source combiner: masked event channels and debugger break
`timescale 1ns/1ps
`default_nettype none
module dtpf_fault (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic [7:0] event_i,
    input  wire logic [7:0] mask_i,
    input  wire logic       dbg_break_i,
    input  wire logic       dbg_ignore_i,
    input  wire logic [1:0] action_i,
    output logic            fault_o
);
    typedef struct packed {
        logic hit;
    } dtpf_flt_t;

    dtpf_flt_t q;
    dtpf_flt_t d;

    always_comb begin
        d     = q;
        d.hit = (action_i != dtpf_pkg::DTPF_ACT_NONE) &&
                ((|(event_i & mask_i)) ||
                 (dbg_break_i && !dbg_ignore_i));
    end

    assign fault_o = q.hit;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    dbg_ignore_a: assert property (dbg_ignore_i && !(|(event_i & mask_i))
        |=> !fault_o)
        else $error("ignored break raised a fault");
endmodule : dtpf_fault
`default_nettype wire

// file: dtpf_timer_model.sv
// timer and port stand-in: waveforms, update pulse, pin directions
`timescale 1ns/1ps
`default_nettype none
module dtpf_timer_model (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic [3:0] wave_req_i,
    input  wire logic       upd_req_i,
    input  wire logic       lupd_req_i,
    input  wire logic [7:0] dir_clr_i,
    input  wire logic [7:0] dir_set_i,
    output logic      [3:0] wave_o,
    output logic            update_o,
    output logic            lupd_o,
    output logic      [7:0] dir_o
);
    logic req_q;
    // every timer output leaves a flop, as the real counter's do
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wave_o   <= 4'h0;
            update_o <= 1'b0;
            lupd_o   <= 1'b0;
            req_q    <= 1'b0;
            dir_o    <= 8'hff;
        end else begin
            wave_o   <= wave_req_i;
            // one update clock per request edge
            update_o <= upd_req_i & ~req_q;
            lupd_o   <= lupd_req_i;
            req_q    <= upd_req_i;
            // clear pulses win, a fault must never be undone
            dir_o    <= (dir_o | dir_set_i) & ~dir_clr_i;
        end
    end
endmodule : dtpf_timer_model
`default_nettype wire

// file: dtpf_top_bench.sv
// self-checking bench for the dead-time, pattern and fault unit
`timescale 1ns/1ps
`default_nettype none
module dtpf_top_bench;
    typedef struct packed {
        logic [7:0] ctrl;
        logic [3:0] wave;
        logic [7:0] oe;
        logic [7:0] pin;
    } dtpf_row_t;
    // dead times still zero here, so pins settle in a few clocks
    localparam dtpf_row_t ROWS [8] = '{
        '{8'h01, 4'h1, 8'h03, 8'h01}, '{8'h03, 4'h2, 8'h0f, 8'h06},
        '{8'h0f, 4'h1, 8'hff, 8'ha9}, '{8'h0c, 4'h4, 8'hf0, 8'h90},
        '{8'h1f, 4'h1, 8'hff, 8'h55}, '{8'h1f, 4'he, 8'hff, 8'haa},
        '{8'h20, 4'h1, 8'hff, 8'hff}, '{8'h20, 4'he, 8'hff, 8'h00}
    };
    logic        clk_i, rst_i, cyc, stb, we, ack, upd, lu, lock, brk;
    logic        err, flt, uq, lq;
    logic [3:0]  wq, wv;
    logic [5:0]  adr;
    logic [7:0]  ev, pin, oe, dc, ds, dir;
    logic [31:0] wd, rdat;
    int          fails, num_checks, a, b, c, d;
    int          tmo;

    dtpf_top i_dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wd),
        .wb_dat_o(rdat), .wb_ack_o(ack), .wave_i(wv), .update_i(upd),
        .lock_upd_i(lu), .lock_i(lock), .fault_event_i(ev),
        .debug_break_i(brk), .pin_o(pin), .pin_oe_o(oe),
        .dir_clr_o(dc), .dir_set_o(ds), .err_set_o(err), .fault_o(flt)
    );
    dtpf_timer_model i_tmr (
        .clk_i(clk_i), .rst_i(rst_i), .wave_req_i(wq), .upd_req_i(uq),
        .lupd_req_i(lq), .dir_clr_i(dc), .dir_set_i(ds), .wave_o(wv),
        .update_o(upd), .lupd_o(lu), .dir_o(dir)
    );

    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // outputs are registered, so ack read right after the edge is the
    // value sampled at that edge
    task automatic wb(input logic w, input logic [5:0] ad,
                      input logic [7:0] dv, output logic [7:0] rv);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= ad;
        wd  <= {24'h0, dv};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (ack !== 1'b1) begin
            fails++;
            $display("Error at %0t: ack %h expected %h", $time, ack, 1'b1);
        end
        rv = rdat[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
    endtask : wb

    task automatic wr(input logic [5:0] ad, input logic [7:0] dv);
        logic [7:0] rv;
        wb(1'b1, ad, dv, rv);
    endtask : wr

    task automatic rdc(input logic [5:0] ad, input logic [7:0] exp);
        logic [7:0] rv;
        wb(1'b0, ad, 8'h00, rv);
        chk(rv, exp);
    endtask : rdc

    task automatic see(input int n);
        repeat (n) @(posedge clk_i);
        @(negedge clk_i);
    endtask : see

    task automatic pulse;
        @(posedge clk_i);
        uq <= 1'b1;
        @(posedge clk_i);
        uq <= 1'b0;
        see(4);
    endtask : pulse

    // clocks from a wave change until the given pin goes high
    task automatic meas(input logic [3:0] w, input int bt, output int n);
        @(posedge clk_i);
        wq <= w;
        n = 0;
        do begin
            @(negedge clk_i);
            n++;
        end while (pin[bt] !== 1'b1 && n < 300);
    endtask : meas

    task automatic evt(input logic [7:0] m, input int n);
        @(posedge clk_i);
        ev <= m;
        repeat (n) @(posedge clk_i);
        ev <= 8'h00;
    endtask : evt

    task automatic run_tests;
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        see(0);
        chk(oe, 8'h00);
        chk({7'h0, flt}, 8'h00);
        rdc(6'h00, 8'h00);
        rdc(6'h10, 8'h00);
        wr(6'h3c, 8'hff);
        rdc(6'h3c, 8'h00);
        wr(6'h30, 8'hff);
        foreach (ROWS[i]) begin
            wr(6'h00, ROWS[i].ctrl);
            @(posedge clk_i);
            wq <= ROWS[i].wave;
            see(6);
            chk(oe, ROWS[i].oe);
            chk(pin & ROWS[i].oe, ROWS[i].pin);
        end
        // dead time: only the difference in delay is fixed by the rules
        wr(6'h00, 8'h01);
        wr(6'h20, 8'h03);
        wr(6'h24, 8'h05);
        @(posedge clk_i);
        wq <= 4'h0;
        see(20);
        meas(4'h1, 0, a);
        meas(4'h0, 1, b);
        chk({6'h0, pin[1:0]}, 8'h02);
        wr(6'h18, 8'h07);
        rdc(6'h24, 8'h07);
        meas(4'h1, 0, c);
        meas(4'h0, 1, d);
        chk(8'(c - a), 8'h04);
        chk(8'(d - b), 8'h02);
        chk({7'h0, a > 3}, 8'h01);
        // buffers move only at an unlocked update
        wr(6'h28, 8'h11);
        wr(6'h2c, 8'h22);
        rdc(6'h20, 8'h07);
        rdc(6'h10, 8'h03);
        lq <= 1'b1;
        pulse();
        rdc(6'h20, 8'h07);
        lq <= 1'b0;
        pulse();
        rdc(6'h20, 8'h11);
        rdc(6'h24, 8'h22);
        // latched clear-override fault
        wr(6'h00, 8'h03);
        wr(6'h08, 8'h04);
        wr(6'h0c, 8'h01);
        evt(8'h08, 3);
        see(2);
        chk({7'h0, flt}, 8'h00);
        evt(8'h04, 1);
        see(1);
        chk({6'h0, flt, err}, 8'h03);
        see(2);
        chk(oe, 8'h00);
        rdc(6'h10, 8'h04);
        pulse();
        chk({7'h0, flt}, 8'h01);
        wr(6'h10, 8'h00);
        rdc(6'h10, 8'h04);
        wr(6'h10, 8'h04);
        rdc(6'h10, 8'h00);
        pulse();
        chk({7'h0, flt}, 8'h00);
        chk(oe, 8'h0f);
        // cycle mode with direction clear
        wr(6'h0c, 8'h07);
        evt(8'h04, 4);
        see(2);
        chk(dir, 8'hf0);
        pulse();
        chk({7'h0, flt}, 8'h00);
        chk(dir, 8'hff);
        wr(6'h10, 8'h04);
        wr(6'h0c, 8'h00);
        evt(8'h04, 2);
        see(2);
        chk({6'h0, flt, err}, 8'h00);
        // debugger break as a fault source, then ignored
        wr(6'h0c, 8'h05);
        @(posedge clk_i);
        brk <= 1'b1;
        see(3);
        chk({7'h0, flt}, 8'h01);
        @(posedge clk_i);
        brk <= 1'b0;
        pulse();
        chk({7'h0, flt}, 8'h00);
        wr(6'h10, 8'h04);
        wr(6'h0c, 8'h15);
        @(posedge clk_i);
        brk <= 1'b1;
        see(3);
        chk({7'h0, flt}, 8'h00);
        @(posedge clk_i);
        brk <= 1'b0;
        // lock holds control and mask
        lock <= 1'b1;
        wr(6'h00, 8'h3f);
        rdc(6'h00, 8'h03);
        wr(6'h08, 8'hff);
        rdc(6'h08, 8'h04);
        lock <= 1'b0;
        wr(6'h00, 8'h01);
        rdc(6'h00, 8'h01);
    endtask : run_tests

    // run is under five hundred clocks, so the limit only trips on a hang
    initial begin
        {cyc, stb, we, lock, brk, uq, lq} = '0;
        adr = '0;
        wd = '0;
        wq = '0;
        ev = '0;
        fails = 0;
        num_checks = 0;
        rst_i = 1'b1;
        fork
            run_tests();
            begin
                for (tmo = 0; tmo < 20000; tmo++) begin
                    @(posedge clk_i);
                end
                fails++;
                $display("Error at %0t: cycles %h limit %h", $time, tmo,
                         20000);
            end
        join_any
        report_and_stop();
    end
endmodule : dtpf_top_bench
`default_nettype wire
